// file: design/derived_system_clock_flags_pkg.sv
// Constants for the system clock status, align select and ratio change block.
// Assumes a single 40 MHz controller clock and an Avalon-MM register slave.
// =====================================================================
// Overview of operation
// - Read-only running bit per derived clock at bits 0 to 5; 1 means running.
// - One align select bit per clock, clock n at bit n-1; 1 means align.
// - Align select bits reset to 1 and are read-only, so all six align.
// - Read-only ratio changed flag per clock at bits 0 to 5.
// - Ratio changed flags reset to 0; bits above 5 read 0 in all three.
// - Writing 1 to the command bit starts a divider load; 0 does nothing.
// - Each divider holds a 3-bit code and divides by code plus one.
package derived_system_clock_flags_pkg;
	localparam int NUM_CLK = 6;
	localparam int RATIO_W = 3;
	// =====================================================================
	// Register word indices (byte address = 4 * index)
	localparam logic [3:0] IDX_ON_STATUS = 4'h0;
	localparam logic [3:0] IDX_ALIGN_SEL = 4'h1;
	localparam logic [3:0] IDX_RATIO_CHG = 4'h2;
	localparam logic [3:0] IDX_CMD = 4'h3;
	localparam logic [3:0] IDX_LOAD_STAT = 4'h4;
	localparam logic [3:0] IDX_IRQ_STAT = 4'h5;
	localparam logic [3:0] IDX_IRQ_MASK = 4'h6;
	localparam logic [3:0] IDX_RATIO_BASE = 4'h8;
	// =====================================================================
	// Reset values and field positions
	localparam logic [5:0] ALIGN_SEL_RESET = 6'h3f;
	localparam logic [5:0] RATIO_CHG_RESET = 6'h00;
	localparam logic [2:0] RATIO_RESET = 3'h3;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	localparam int CMD_BIT = 0;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_CHG_BIT = 1;
	// Load sequence length in controller cycles
	localparam logic [3:0] LOAD_CYCLES = 4'h8;
	typedef enum logic [1:0] {IDLE, LOADING, FINISH} load_state_type;
endpackage

// file: design/derived_system_clock_flags.sv
// Register slave for clock running status, align select and ratio change flags,
// with six ratio dividers and the divider load sequencer.
// Assumes Avalon-MM master on CLK_IN; clock enables driven elsewhere arrive asynchronously.
`timescale 1ns/10ps
module derived_system_clock_flags (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic NRST_IN,
	// Avalon-MM slave
	input wire logic [5:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	// Clock gating inputs from outside
	input wire logic [5:0] CLK_GATE_EN_IN,
	// Derived clocks
	output logic [5:0] DERIVED_CLK_OUT,
	// Interrupt
	output logic IRQ_OUT
);
	// =====================================================================
	// Synchroniser
	logic [5:0] en_meta_reg, en_meta_next, en_sync_reg, en_sync_next;
	always_comb begin
		en_meta_next = CLK_GATE_EN_IN;
		en_sync_next = en_meta_reg;
	end
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			en_meta_reg <= 6'h00;
			en_sync_reg <= 6'h00;
		end else begin
			en_meta_reg <= en_meta_next;
			en_sync_reg <= en_sync_next;
		end
	end

	// =====================================================================
	// Bus, ratios, flags, sequencer
	// One wait cycle per access so read data come from a flip-flop.
	logic ack_reg, ack_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [2:0] ratio_reg [6], ratio_next [6];
	logic [2:0] active_reg [6], active_next [6];
	logic [5:0] chg_reg, chg_next;
	logic [5:0] align_reg, align_next;
	logic [1:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
	logic irq_reg, irq_next;
	logic [3:0] cnt_reg, cnt_next;
	derived_system_clock_flags_pkg::load_state_type st_reg, st_next;
	logic [3:0] idx;
	logic wr, rd, done_ev, chg_ev;

	always_comb begin
		idx = AVS_ADDRESS_IN[5:2];
		// Writes land at the edge where the master sees waitrequest low
		wr = AVS_WRITE_IN && ack_reg;
		rd = AVS_READ_IN && !ack_reg;
		ack_next = (AVS_READ_IN || AVS_WRITE_IN) && !ack_reg;
		align_next = align_reg;
		chg_next = chg_reg;
		st_next = st_reg;
		cnt_next = cnt_reg;
		done_ev = 1'b0;
		chg_ev = 1'b0;
		irq_mask_next = irq_mask_reg;
		for (int i = 0; i < 6; i++) begin
			ratio_next[i] = ratio_reg[i];
			active_next[i] = active_reg[i];
		end
		// Sequencer
		case (st_reg)
			derived_system_clock_flags_pkg::IDLE: begin
				if (wr && idx == derived_system_clock_flags_pkg::IDX_CMD
				    && AVS_WRITEDATA_IN[derived_system_clock_flags_pkg::CMD_BIT]) begin
					st_next = derived_system_clock_flags_pkg::LOADING;
					cnt_next = derived_system_clock_flags_pkg::LOAD_CYCLES;
				end
			end
			derived_system_clock_flags_pkg::LOADING: begin
				cnt_next = cnt_reg - 4'h1;
				if (cnt_reg == 4'h1) begin
					st_next = derived_system_clock_flags_pkg::FINISH;
				end
			end
			derived_system_clock_flags_pkg::FINISH: begin
				for (int i = 0; i < 6; i++) begin
					if (align_reg[i]) begin
						active_next[i] = ratio_reg[i];
					end
				end
				chg_next = derived_system_clock_flags_pkg::RATIO_CHG_RESET;
				done_ev = 1'b1;
				st_next = derived_system_clock_flags_pkg::IDLE;
			end
			default: st_next = derived_system_clock_flags_pkg::IDLE;
		endcase
		// Ratio writes; a set in the clearing cycle wins
		for (int i = 0; i < 6; i++) begin
			if (wr && idx == derived_system_clock_flags_pkg::IDX_RATIO_BASE + 4'(i)) begin
				ratio_next[i] = AVS_WRITEDATA_IN[2:0];
				if (AVS_WRITEDATA_IN[2:0] != ratio_reg[i]) begin
					chg_next[i] = 1'b1;
					chg_ev = 1'b1;
				end
			end
		end
		if (wr && idx == derived_system_clock_flags_pkg::IDX_IRQ_MASK) begin
			irq_mask_next = AVS_WRITEDATA_IN[1:0];
		end
		irq_stat_next = irq_stat_reg;
		if (wr && idx == derived_system_clock_flags_pkg::IDX_IRQ_STAT) begin
			irq_stat_next = irq_stat_reg & ~AVS_WRITEDATA_IN[1:0];
		end
		irq_stat_next[derived_system_clock_flags_pkg::IRQ_DONE_BIT] =
			irq_stat_next[derived_system_clock_flags_pkg::IRQ_DONE_BIT] | done_ev;
		irq_stat_next[derived_system_clock_flags_pkg::IRQ_CHG_BIT] =
			irq_stat_next[derived_system_clock_flags_pkg::IRQ_CHG_BIT] | chg_ev;
		irq_next = |(irq_stat_next & irq_mask_next);
		// Read mux; upper bits stay zero
		rdata_next = 32'h0000_0000;
		if (rd) begin
			case (idx)
				derived_system_clock_flags_pkg::IDX_ON_STATUS: rdata_next[5:0] = en_sync_reg;
				derived_system_clock_flags_pkg::IDX_ALIGN_SEL: rdata_next[5:0] = align_reg;
				derived_system_clock_flags_pkg::IDX_RATIO_CHG: rdata_next[5:0] = chg_reg;
				derived_system_clock_flags_pkg::IDX_LOAD_STAT: rdata_next[0] = (st_reg != derived_system_clock_flags_pkg::IDLE);
				derived_system_clock_flags_pkg::IDX_IRQ_STAT: rdata_next[1:0] = irq_stat_reg;
				derived_system_clock_flags_pkg::IDX_IRQ_MASK: rdata_next[1:0] = irq_mask_reg;
				default: begin
					for (int i = 0; i < 6; i++) begin
						if (idx == derived_system_clock_flags_pkg::IDX_RATIO_BASE + 4'(i)) begin
							rdata_next[2:0] = ratio_reg[i];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			chg_reg <= derived_system_clock_flags_pkg::RATIO_CHG_RESET;
			align_reg <= derived_system_clock_flags_pkg::ALIGN_SEL_RESET;
			irq_stat_reg <= derived_system_clock_flags_pkg::IRQ_RESET;
			irq_mask_reg <= derived_system_clock_flags_pkg::IRQ_RESET;
			irq_reg <= 1'b0;
			cnt_reg <= 4'h0;
			st_reg <= derived_system_clock_flags_pkg::IDLE;
			for (int i = 0; i < 6; i++) begin
				ratio_reg[i] <= derived_system_clock_flags_pkg::RATIO_RESET;
				active_reg[i] <= derived_system_clock_flags_pkg::RATIO_RESET;
			end
		end else begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
			chg_reg <= chg_next;
			align_reg <= align_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			irq_reg <= irq_next;
			cnt_reg <= cnt_next;
			st_reg <= st_next;
			for (int i = 0; i < 6; i++) begin
				ratio_reg[i] <= ratio_next[i];
				active_reg[i] <= active_next[i];
			end
		end
	end

	// =====================================================================
	// Dividers: toggle-free pulse clock, high one cycle in code plus one
	// Limitation: output is a one-in-N enable, not a 50 percent clock.
	logic [2:0] div_reg [6], div_next [6];
	logic [5:0] dclk_reg, dclk_next;
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			if (st_reg == derived_system_clock_flags_pkg::FINISH && align_reg[i]) begin
				div_next[i] = 3'h0; // Common restart gives phase alignment
				dclk_next[i] = 1'b0;
			end else if (div_reg[i] >= active_reg[i]) begin
				div_next[i] = 3'h0;
				dclk_next[i] = en_sync_reg[i];
			end else begin
				div_next[i] = div_reg[i] + 3'h1;
				dclk_next[i] = 1'b0;
			end
		end
	end
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			dclk_reg <= 6'h00;
			for (int i = 0; i < 6; i++) begin
				div_reg[i] <= 3'h0;
			end
		end else begin
			dclk_reg <= dclk_next;
			for (int i = 0; i < 6; i++) begin
				div_reg[i] <= div_next[i];
			end
		end
	end

	always_comb begin
		AVS_READDATA_OUT = rdata_reg;
		AVS_WAITREQUEST_OUT = !ack_reg;
		DERIVED_CLK_OUT = dclk_reg;
		IRQ_OUT = irq_reg;
	end

	// =====================================================================
	// Checks
	property p_align_fixed;
		@(posedge CLK_IN) disable iff (!NRST_IN) align_reg == 6'h3f;
	endproperty
	a_align_fixed: assert property (p_align_fixed) else $error("align select changed");
	property p_flags_clear;
		@(posedge CLK_IN) disable iff (!NRST_IN)
			st_reg == derived_system_clock_flags_pkg::FINISH && !wr |=> chg_reg == 6'h00;
	endproperty
	a_flags_clear: assert property (p_flags_clear) else $error("flags not cleared");
	sequence s_go;
		st_reg == derived_system_clock_flags_pkg::IDLE && st_next == derived_system_clock_flags_pkg::LOADING;
	endsequence
	property p_load_len;
		@(posedge CLK_IN) disable iff (!NRST_IN) s_go |-> ##9 st_reg == derived_system_clock_flags_pkg::FINISH;
	endproperty
	a_load_len: assert property (p_load_len) else $error("load length wrong");
	property p_upper_zero;
		@(posedge CLK_IN) disable iff (!NRST_IN) rdata_reg[31:6] == 26'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
	property p_status_read;
		@(posedge CLK_IN) disable iff (!NRST_IN)
			rd && idx == derived_system_clock_flags_pkg::IDX_ON_STATUS |=> rdata_reg[5:0] == $past(en_sync_reg);
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read wrong");
	property p_chg_set;
		@(posedge CLK_IN) disable iff (!NRST_IN)
			wr && idx == derived_system_clock_flags_pkg::IDX_RATIO_BASE
			&& AVS_WRITEDATA_IN[2:0] != ratio_reg[0] |=> chg_reg[0];
	endproperty
	a_chg_set: assert property (p_chg_set) else $error("change flag not set");
	property p_div_period;
		@(posedge CLK_IN) disable iff (!NRST_IN)
			dclk_reg[0] && active_reg[0] == 3'h1 && st_reg == derived_system_clock_flags_pkg::IDLE
			|=> !dclk_reg[0] ##1 dclk_reg[0] == $past(en_sync_reg[0]);
	endproperty
	a_div_period: assert property (p_div_period) else $error("divider period wrong");
	property p_align_read;
		@(posedge CLK_IN) disable iff (!NRST_IN)
			rd && idx == derived_system_clock_flags_pkg::IDX_ALIGN_SEL |=> rdata_reg[5:0] == 6'h3f;
	endproperty
	a_align_read: assert property (p_align_read) else $error("align read wrong");
endmodule

// file: sim/test_derived_system_clock_flags.sv
// Self-checking bench for the clock status, align select and ratio change block.
// Assumes the design package and module compile first; one 40 MHz clock.
`timescale 1ns/10ps
module test_derived_system_clock_flags;
	// =====================================================================
	// Stimulus and observation
	logic clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0, wait_req, irq;
	logic [5:0] addr = 6'h00, gate = 6'h00, dclk;
	logic [31:0] wdata = 32'h0, rdata, q, exp_chg;
	logic [2:0] rat [6];
	int error_cnt = 0, tests_run = 0, cyc = 0, seed = 32'hf5101874, p;
	derived_system_clock_flags uut (.CLK_IN(clk), .NRST_IN(nrst), .AVS_ADDRESS_IN(addr),
		.AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
		.AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_req),
		.CLK_GATE_EN_IN(gate), .DERIVED_CLK_OUT(dclk), .IRQ_OUT(irq));
	initial begin
		forever #12.5 clk = ~clk;
	end
	// Cut a hang short; the whole run needs well under 5000 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end
	// =====================================================================
	// Tasks
	task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= ~w;
		wr <= w;
		wdata <= d;
		// Only the bench timeout ends a wait for the answer
		do begin
			@(posedge clk);
		end while (wait_req !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		chk(q, exp);
	endtask
	// Cycles between two pulses of one derived clock
	task automatic period(input int k, output int n);
		int m;
		m = 0;
		n = 0;
		while (dclk[k] !== 1'b1 && m < 50) begin
			@(posedge clk);
			m++;
		end
		do begin
			@(posedge clk);
			n++;
		end while (dclk[k] !== 1'b1 && n < 50);
	endtask
	function automatic logic [31:0] chg_bit(input int k, input logic [2:0] o, input logic [2:0] c);
		return (o != c) ? (32'h1 << k) : 32'h0;
	endfunction
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// =====================================================================
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		rchk(6'h04, 32'h3f);
		bus(6'h04, 1'b1, 32'h0);
		rchk(6'h04, 32'h3f);
		rchk(6'h08, 32'h0);
		rchk(6'h3c, 32'h0);
		$display("Reset values done");
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			gate <= (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($random(seed));
			repeat (4) @(posedge clk);
			rchk(6'h00, {26'h0, gate});
		end
		gate <= 6'h3f;
		$display("Running status done");
		bus(6'h18, 1'b1, 32'h3);
		exp_chg = 32'h0;
		for (int k = 0; k < 6; k++) begin
			logic [2:0] c;
			// Corner cases: divide by two on clock 1, unchanged ratio on clock 6
			c = (k == 5) ? 3'h3 : (k == 0) ? 3'h1 : 3'($random(seed));
			exp_chg |= chg_bit(k, 3'h3, c);
			rat[k] = c;
			bus(6'(8'h20 + 4 * k), 1'b1, {29'h0, c});
			rchk(6'h08, exp_chg);
		end
		bus(6'h20, 1'b1, {29'h0, rat[0]});
		rchk(6'h08, exp_chg);
		if (exp_chg != 32'h0) begin
			rchk(6'h14, 32'h2);
			chk({31'h0, irq}, 32'h1);
		end
		bus(6'h14, 1'b1, 32'h3);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		$display("Ratio flags done");
		bus(6'h0c, 1'b1, 32'h0);
		rchk(6'h10, 32'h0);
		bus(6'h0c, 1'b1, 32'h1);
		rchk(6'h10, 32'h1);
		p = 0;
		do begin
			bus(6'h10, 1'b0, 32'h0);
			p++;
		end while (q !== 32'h0 && p < 20);
		chk(q, 32'h0);
		rchk(6'h08, 32'h0);
		rchk(6'h14, 32'h1);
		chk({31'h0, irq}, 32'h1);
		bus(6'h18, 1'b1, 32'h0);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		$display("Divider load done");
		for (int k = 0; k < 6; k++) begin
			period(k, p);
			chk(32'(p), 32'(rat[k]) + 32'h1);
		end
		@(posedge clk);
		gate <= 6'h00;
		repeat (5) @(posedge clk);
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			chk({26'h0, dclk}, 32'h0);
		end
		$display("Divider periods done");
		finish_test();
	end
endmodule
